// File: verilog/dtio_pkg.sv
package dtio_pkg;
localparam int CLK_HZ = 125_000_000;
localparam int MS_PER_S = 1000;
localparam int CLK_PER_MS = CLK_HZ / MS_PER_S;
localparam int MS_DIV_W = 17;
localparam int WORD_B = 4;
localparam int N_PIN = 5;
localparam int N_OUT = 10;
localparam int N_VDI = 4;
localparam int COND_W = 44;
localparam int DIG_W = 4;
// filter and ready times in ms
localparam logic [6:0] FILT_MS_MAX = 7'h64;
localparam logic [6:0] FILT_MS_RST = 7'h0a;
localparam logic [14:0] READY_MS_MAX = 15'h7530;
localparam logic [14:0] READY_MS_RST = 15'h03e8;
localparam int PIN_RUN = 0;
localparam int PIN_DIR = 1;
localparam int PIN_STOP = 2;
localparam int IDX_RELAY1 = 2;
localparam int IDX_RELAY2 = 3;
localparam int IDX_CARD_LO = 4;
localparam int IDX_CARD_HI = 7;
localparam int FIT_CARD = 0;
localparam int FIT_RELAY2 = 1;
localparam logic [7:0] FC_NONE = 8'h00;
localparam logic [7:0] FC_ANY_FAULT = 8'h03;
localparam logic [7:0] FC_RSV_A = 8'h18;
localparam logic [7:0] FC_RSV_LO = 8'h1d;
localparam logic [7:0] FC_RSV_HI = 8'h1f;
localparam logic [7:0] FC_LAST = 8'h2b;
localparam logic [15:0] VSRC_RST01 = 16'h0600;
localparam logic [15:0] VSRC_RST2 = 16'h0700;
localparam logic [15:0] VSRC_RST3 = 16'h4400;
localparam logic [7:0] REG_STATUS = 8'h00;
localparam logic [7:0] REG_FSEL0 = 8'h04;
localparam logic [7:0] REG_FILT = 8'h2c;
localparam logic [7:0] REG_READY = 8'h30;
localparam logic [7:0] REG_PROT = 8'h34;
localparam logic [7:0] REG_VCTL = 8'h38;
localparam logic [7:0] REG_VSRC0 = 8'h3c;
localparam logic [7:0] REG_FIT = 8'h4c;
localparam logic [7:0] REG_INSTAT = 8'h50;

typedef enum logic [1:0] {ST_WAIT = 2'b00, ST_STOP = 2'b01, ST_RUN = 2'b11, ST_BLOCK = 2'b10} dtio_run_e;

typedef struct packed {
   logic run;
   logic reverse;
} dtio_cmd_s;

typedef struct packed {
   logic [N_PIN-1:0] s1;
   logic [N_PIN-1:0] s2;
   logic [N_PIN-1:0] s3;
   logic [N_PIN-1:0] filt;
   logic [N_PIN-1:0][6:0] fcnt;
   logic [MS_DIV_W-1:0] div;
   logic tick;
   logic [14:0] rcnt;
   dtio_run_e st;
   logic run_prev;
   logic run;
   logic rev;
   logic [N_OUT-1:0][7:0] fsel;
   logic [6:0] filt_ms;
   logic [14:0] ready_ms;
   logic prot;
   logic [15:0] vctl;
   logic [N_VDI-1:0][15:0] vsrc;
   logic [1:0] fit;
   logic [N_OUT-1:0] outs;
   logic [N_VDI-1:0] vin;
   logic waitreq;
   logic [31:0] rdata;
} dtio_state_s;
endpackage : dtio_pkg

// File: verilog/dtio_top.sv
module dtio_top #(
   parameter int CLK_PER_MS = dtio_pkg::CLK_PER_MS
) (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic [dtio_pkg::N_PIN-1:0] term_pins,
   input wire logic [dtio_pkg::COND_W-1:0] drive_cond,
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output logic [dtio_pkg::N_OUT-1:0] out_state,
   output logic [dtio_pkg::N_VDI-1:0] virtual_in,
   output dtio_pkg::dtio_cmd_s drive_cmd
);

   localparam logic [dtio_pkg::MS_DIV_W-1:0] DIV_LAST = dtio_pkg::MS_DIV_W'(CLK_PER_MS - 1);

   dtio_pkg::dtio_state_s r;
   dtio_pkg::dtio_state_s n;
   logic [dtio_pkg::N_OUT-1:0] present;
   logic [31:0] rd_mux;
   logic req;
   logic press;

   // reserved and unassigned codes select nothing
   function automatic logic sel_cond(input logic [7:0] code, input logic [dtio_pkg::COND_W-1:0] vec);
      logic hit;
      hit = 1'b0;
      if (code != dtio_pkg::FC_NONE && code != dtio_pkg::FC_RSV_A && code <= dtio_pkg::FC_LAST
          && !(code >= dtio_pkg::FC_RSV_LO && code <= dtio_pkg::FC_RSV_HI))
      begin
         hit = vec[code[5:0]];
      end
      return hit;
   endfunction : sel_cond

   function automatic logic [7:0] reg_addr(input logic [7:0] base, input int idx);
      return base + 8'(idx * dtio_pkg::WORD_B);
   endfunction : reg_addr

   always_comb
   begin
      n = r;
      req = avs_read | avs_write;
      present = '1;
      rd_mux = '0;
      // timebase for filter and ready timers
      n.tick = (r.div == DIV_LAST);
      n.div = n.tick ? '0 : r.div + 1'b1;
      // pin synchronisers, first stage read only by the second
      n.s1 = term_pins;
      n.s2 = r.s1;
      n.s3 = r.s2;
      for (int i = 0; i < dtio_pkg::N_PIN; i++)
      begin
         if (r.s2[i] == r.s3[i] && r.s3[i] != r.filt[i])
         begin
            if (r.fcnt[i] >= r.filt_ms)
            begin
               n.filt[i] = r.s3[i];
               n.fcnt[i] = '0;
            end
            else if (r.tick)
            begin
               n.fcnt[i] = r.fcnt[i] + 1'b1;
            end
         end
         else
         begin
            n.fcnt[i] = '0;
         end
      end

      if (r.st == dtio_pkg::ST_WAIT && r.tick && r.rcnt < r.ready_ms)
      begin
         n.rcnt = r.rcnt + 1'b1;
      end

      press = r.filt[dtio_pkg::PIN_RUN] & ~r.run_prev;
      n.run_prev = r.filt[dtio_pkg::PIN_RUN];
      unique case (r.st)
         dtio_pkg::ST_WAIT:
         begin
            if (r.rcnt >= r.ready_ms)
            begin
               // run active at power-on is refused when protection is set
               if (r.filt[dtio_pkg::PIN_RUN] && r.prot)
               begin
                  n.st = dtio_pkg::ST_BLOCK;
               end
               else if (r.filt[dtio_pkg::PIN_RUN] && r.filt[dtio_pkg::PIN_STOP])
               begin
                  n.st = dtio_pkg::ST_RUN;
               end
               else
               begin
                  n.st = dtio_pkg::ST_STOP;
               end
            end
         end
         dtio_pkg::ST_BLOCK:
         begin
            if (!r.filt[dtio_pkg::PIN_RUN])
            begin
               n.st = dtio_pkg::ST_STOP;
            end
         end
         dtio_pkg::ST_STOP:
         begin
            if (press && r.filt[dtio_pkg::PIN_STOP])
            begin
               n.st = dtio_pkg::ST_RUN;
            end
         end
         dtio_pkg::ST_RUN:
         begin
            if (!r.filt[dtio_pkg::PIN_STOP])
            begin
               n.st = dtio_pkg::ST_STOP;
            end
         end
      endcase
      n.run = (n.st == dtio_pkg::ST_RUN);
      n.rev = r.filt[dtio_pkg::PIN_DIR];

      for (int k = 0; k < dtio_pkg::N_VDI; k++)
      begin
         n.vin[k] = (r.vctl[k*dtio_pkg::DIG_W +: dtio_pkg::DIG_W] == '0) && sel_cond(r.vsrc[k][7:0], drive_cond);
      end

      present[dtio_pkg::IDX_CARD_HI:dtio_pkg::IDX_CARD_LO] = {4{r.fit[dtio_pkg::FIT_CARD]}};
      present[dtio_pkg::IDX_RELAY2] = r.fit[dtio_pkg::FIT_RELAY2];
      for (int j = 0; j < dtio_pkg::N_OUT; j++)
      begin
         n.outs[j] = present[j] & sel_cond(r.fsel[j], drive_cond);
      end

      // register read decode; unmapped words read zero
      // status word in output order
      if (avs_address == dtio_pkg::REG_STATUS)
      begin
         rd_mux = 32'(r.outs);
      end
      if (avs_address == dtio_pkg::REG_FILT)
      begin
         rd_mux = 32'(r.filt_ms);
      end
      if (avs_address == dtio_pkg::REG_READY)
      begin
         rd_mux = 32'(r.ready_ms);
      end
      if (avs_address == dtio_pkg::REG_PROT)
      begin
         rd_mux = 32'(r.prot);
      end
      if (avs_address == dtio_pkg::REG_VCTL)
      begin
         rd_mux = 32'(r.vctl);
      end
      if (avs_address == dtio_pkg::REG_FIT)
      begin
         rd_mux = 32'(r.fit);
      end
      if (avs_address == dtio_pkg::REG_INSTAT)
      begin
         rd_mux = 32'({r.vin, r.rev, r.run, r.st, r.filt});
      end
      for (int j = 0; j < dtio_pkg::N_OUT; j++)
      begin
         if (avs_address == reg_addr(dtio_pkg::REG_FSEL0, j))
         begin
            rd_mux = 32'(r.fsel[j]);
         end
      end
      for (int k = 0; k < dtio_pkg::N_VDI; k++)
      begin
         if (avs_address == reg_addr(dtio_pkg::REG_VSRC0, k))
         begin
            rd_mux = 32'(r.vsrc[k]);
         end
      end

      // one wait cycle, then the access completes on the edge that sees waitrequest low
      if (req && r.waitreq)
      begin
         n.waitreq = 1'b0;
         n.rdata = rd_mux;
      end
      else if (req)
      begin
         n.waitreq = 1'b1;
         if (avs_write)
         begin
            // times above the documented maximum clamp to it; write bits above the 7- or 15-bit field are dropped first
            if (avs_address == dtio_pkg::REG_FILT)
            begin
               n.filt_ms = (avs_writedata[6:0] > dtio_pkg::FILT_MS_MAX) ? dtio_pkg::FILT_MS_MAX : avs_writedata[6:0];
            end
            if (avs_address == dtio_pkg::REG_READY)
            begin
               n.ready_ms = (avs_writedata[14:0] > dtio_pkg::READY_MS_MAX) ? dtio_pkg::READY_MS_MAX
                                                                           : avs_writedata[14:0];
            end
            if (avs_address == dtio_pkg::REG_PROT)
            begin
               n.prot = avs_writedata[0];
            end
            if (avs_address == dtio_pkg::REG_VCTL)
            begin
               n.vctl = avs_writedata[15:0];
            end
            if (avs_address == dtio_pkg::REG_FIT)
            begin
               n.fit = avs_writedata[1:0];
            end
            for (int j = 0; j < dtio_pkg::N_OUT; j++)
            begin
               if (avs_address == reg_addr(dtio_pkg::REG_FSEL0, j))
               begin
                  n.fsel[j] = avs_writedata[7:0];
               end
            end
            for (int k = 0; k < dtio_pkg::N_VDI; k++)
            begin
               if (avs_address == reg_addr(dtio_pkg::REG_VSRC0, k))
               begin
                  n.vsrc[k] = avs_writedata[15:0];
               end
            end
         end
      end
   end

   always_ff @(posedge clk_sys or posedge reset)
   begin
      if (reset)
      begin
         r <= '0;
         r.st <= dtio_pkg::ST_WAIT;
         r.filt_ms <= dtio_pkg::FILT_MS_RST;
         r.ready_ms <= dtio_pkg::READY_MS_RST;
         // relay one defaults to any fault
         r.fsel[dtio_pkg::IDX_RELAY1] <= dtio_pkg::FC_ANY_FAULT;
         r.vsrc[0] <= dtio_pkg::VSRC_RST01;
         r.vsrc[1] <= dtio_pkg::VSRC_RST01;
         r.vsrc[2] <= dtio_pkg::VSRC_RST2;
         r.vsrc[3] <= dtio_pkg::VSRC_RST3;
         r.waitreq <= 1'b1;
      end
      else
      begin
         r <= n;
      end
   end

   assign avs_readdata = r.rdata;
   assign avs_waitrequest = r.waitreq;
   assign out_state = r.outs;
   assign virtual_in = r.vin;
   assign drive_cmd.run = r.run;
   assign drive_cmd.reverse = r.rev;

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (reset);

   sequence s_ready_run;
      r.st == dtio_pkg::ST_WAIT && r.rcnt >= r.ready_ms && r.filt[dtio_pkg::PIN_RUN];
   endsequence

   sequence s_stop_open;
      r.run && !r.filt[dtio_pkg::PIN_STOP];
   endsequence

   property p_start;
      r.st == dtio_pkg::ST_STOP && r.filt[dtio_pkg::PIN_STOP] && r.filt[dtio_pkg::PIN_RUN] && !r.run_prev |=> r.run;
   endproperty
   a_start: assert property (p_start) else $error("run press with stop closed did not start");

   property p_dir;
      $stable(r.filt[dtio_pkg::PIN_DIR]) |=> r.rev == $past(r.filt[dtio_pkg::PIN_DIR]);
   endproperty
   a_dir: assert property (p_dir) else $error("direction does not follow switch");

   property p_stop;
      s_stop_open |=> !r.run ##1 (r.st != dtio_pkg::ST_BLOCK);
   endproperty
   a_stop: assert property (p_stop) else $error("open stop input did not stop drive");

   property p_filt;
      $changed(r.filt[dtio_pkg::PIN_STOP]) |-> $past(r.fcnt[dtio_pkg::PIN_STOP]) >= $past(r.filt_ms)
         && r.filt[dtio_pkg::PIN_STOP] == $past(r.s3[dtio_pkg::PIN_STOP]);
   endproperty
   a_filt: assert property (p_filt) else $error("filtered input changed before filter time");

   property p_noprot;
      s_ready_run and (!r.prot && r.filt[dtio_pkg::PIN_STOP]) |=> r.run;
   endproperty
   a_noprot: assert property (p_noprot) else $error("power-on run terminal ignored without protection");

   property p_prot;
      s_ready_run and r.prot |=> !r.run ##1 !r.run;
   endproperty
   a_prot: assert property (p_prot) else $error("protected power-on run terminal started drive");

   property p_ready;
      r.st == dtio_pkg::ST_WAIT && r.rcnt < r.ready_ms |=> !r.run;
   endproperty
   a_ready: assert property (p_ready) else $error("drive ran before ready time elapsed");

   property p_mux;
      1'b1 |=> r.outs[0] == $past(sel_cond(r.fsel[0], drive_cond));
   endproperty
   a_mux: assert property (p_mux) else $error("output one does not follow its selected condition");

   property p_rsv;
      r.fsel[0] == dtio_pkg::FC_RSV_A |=> !r.outs[0];
   endproperty
   a_rsv: assert property (p_rsv) else $error("reserved code drove output one");

   property p_absent;
      !r.fit[dtio_pkg::FIT_CARD] |=> r.outs[dtio_pkg::IDX_CARD_HI:dtio_pkg::IDX_CARD_LO] == '0;
   endproperty
   a_absent: assert property (p_absent) else $error("absent card outputs active");

endmodule : dtio_top

// File: tb/dtio_panel.sv
module dtio_panel (
   input wire logic clk_sys,
   input wire logic run_btn,
   input wire logic dir_sw,
   input wire logic stop_btn,
   output logic [4:0] term_pins
);
   timeunit 1ns;
   timeprecision 1ps;
   logic prev_r = 1'b0;
   logic [1:0] bounce_r = 2'h0;
   logic chat_r = 1'b0;
   // the run contact chatters for three cycles after each change, then settles to a clean level
   always @(posedge clk_sys)
   begin
      prev_r <= run_btn;
      if (run_btn != prev_r)
         bounce_r <= 2'h3;
      else if (bounce_r != 2'h0)
         bounce_r <= bounce_r - 2'h1;
      chat_r <= (bounce_r != 2'h0) ? ~chat_r : 1'b0;
   end
   assign term_pins = {2'b00, stop_btn, dir_sw, run_btn ^ chat_r};
endmodule : dtio_panel

// File: tb/tb.sv
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys = 1'b0;
   logic reset = 1'b1;
   logic [dtio_pkg::N_PIN-1:0] term_pins;
   logic [dtio_pkg::COND_W-1:0] drive_cond = '0;
   logic [7:0] avs_address = 8'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic [dtio_pkg::N_OUT-1:0] out_state;
   logic [dtio_pkg::N_VDI-1:0] virtual_in;
   dtio_pkg::dtio_cmd_s drive_cmd;
   logic run_btn = 1'b0;
   logic dir_sw = 1'b0;
   logic stop_btn = 1'b1;
   logic [31:0] rd;
   logic [dtio_pkg::COND_W-1:0] oh;
   logic e;
   int fails = 0;
   int n_tests = 0;
   int cycles = 0;
   // address beside the value it must read after reset
   logic [39:0] rows [14] = '{40'h0000000000, 40'h0400000000, 40'h0800000000, 40'h0c00000003,
      40'h1000000000, 40'h2400000000, 40'h2c0000000a, 40'h30000003e8, 40'h3400000000,
      40'h3800000000, 40'h3c00000600, 40'h4400000700, 40'h4800004400, 40'hfc00000000};

   dtio_top #(.CLK_PER_MS(8)) i_dtio_top (.clk_sys(clk_sys), .reset(reset), .term_pins(term_pins),
      .drive_cond(drive_cond), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .out_state(out_state), .virtual_in(virtual_in), .drive_cmd(drive_cmd));
   dtio_panel i_dtio_panel (.clk_sys(clk_sys), .run_btn(run_btn), .dir_sw(dir_sw), .stop_btn(stop_btn),
      .term_pins(term_pins));

   initial
   begin
      forever #4 clk_sys = ~clk_sys;
   end

   task complete_run;
      $display("comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : complete_run

   // a hang ends the run as a mismatch
   always @(posedge clk_sys)
   begin
      cycles++;
      if (cycles == 40000)
      begin
         fails++;
         complete_run();
      end
   end

   task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         fails++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   // one access; held until waitrequest is sampled low
   task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= ~wr;
      @(posedge clk_sys);
      // no cycle limit here: the bench timeout ends a hang
      while (avs_waitrequest !== 1'b0)
      begin
         @(posedge clk_sys);
         n++;
      end
      rd = avs_readdata;
      // one wait cycle per access
      check("bus_wait", 32'(n), 32'h1);
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge clk_sys);
   endtask : bus

   task wait_run(input logic exp, input int lim);
      int n;
      n = 0;
      while (drive_cmd.run !== exp && n < lim)
      begin
         @(posedge clk_sys);
         n++;
      end
      check("run", drive_cmd.run, exp);
   endtask : wait_run

   task do_reset;
      reset <= 1'b1;
      repeat (2) @(posedge clk_sys);
      reset <= 1'b0;
      @(posedge clk_sys);
   endtask : do_reset

   initial
   begin
      do_reset();
      foreach (rows[i])
      begin
         bus(1'b0, rows[i][39:32], 32'h0);
         check($sformatf("reg_%h", rows[i][39:32]), rd, rows[i][31:0]);
      end
      bus(1'b1, 8'hf0, 32'h5);
      bus(1'b0, 8'hf0, 32'h0);
      check("unmapped", rd, 32'h0);
      bus(1'b1, 8'h2c, 32'h7f);
      bus(1'b0, 8'h2c, 32'h0);
      check("filter_clamp", rd, 32'h64);
      $display("test reset_values done");
      // codes 0 to 47, one condition at a time
      bus(1'b1, 8'h4c, 32'h3);
      for (int k = 0; k < 48; k++)
      begin
         oh = '0;
         if (k < dtio_pkg::COND_W)
            oh[k] = 1'b1;
         e = (k >= 1 && k <= 43 && k != 24 && (k < 29 || k > 31));
         bus(1'b1, 8'h04, 32'(k));
         drive_cond <= oh;
         repeat (3) @(posedge clk_sys);
         check($sformatf("code_%0d_on", k), out_state[0], e);
         drive_cond <= ~oh;
         repeat (3) @(posedge clk_sys);
         check($sformatf("code_%0d_off", k), out_state[0], 32'h0);
      end
      $display("test output_codes done");
      drive_cond <= '1;
      bus(1'b1, 8'h4c, 32'h0);
      bus(1'b1, 8'h04, 32'h0);
      bus(1'b1, 8'h10, 32'h1);
      bus(1'b1, 8'h14, 32'h1);
      bus(1'b1, 8'h20, 32'h1);
      bus(1'b1, 8'h24, 32'h1);
      bus(1'b1, 8'h28, 32'h2);
      bus(1'b0, 8'h00, 32'h0);
      check("status_absent", rd, 32'h304);
      check("out_absent", out_state, 32'h304);
      bus(1'b1, 8'h4c, 32'h3);
      bus(1'b1, 8'h00, 32'h0);
      bus(1'b0, 8'h00, 32'h0);
      check("status_fitted", rd, 32'h39c);
      bus(1'b1, 8'h3c, 32'h5);
      oh = '0;
      oh[5] = 1'b1;
      drive_cond <= oh;
      repeat (3) @(posedge clk_sys);
      check("vin_follow", virtual_in[0], 32'h1);
      bus(1'b1, 8'h38, 32'h1);
      repeat (3) @(posedge clk_sys);
      check("vin_digit", virtual_in[0], 32'h0);
      $display("test outputs_and_virtual done");
      bus(1'b1, 8'h30, 32'h0);
      bus(1'b1, 8'h2c, 32'h2);
      dir_sw <= 1'b1;
      repeat (10) @(posedge clk_sys);
      run_btn <= 1'b1;
      repeat (4) @(posedge clk_sys);
      run_btn <= 1'b0;
      repeat (60) @(posedge clk_sys);
      check("glitch", drive_cmd.run, 32'h0);
      run_btn <= 1'b1;
      wait_run(1'b1, 100);
      check("reverse", drive_cmd.reverse, 32'h1);
      run_btn <= 1'b0;
      dir_sw <= 1'b0;
      repeat (60) @(posedge clk_sys);
      check("latched", drive_cmd.run, 32'h1);
      check("forward", drive_cmd.reverse, 32'h0);
      stop_btn <= 1'b0;
      wait_run(1'b0, 100);
      run_btn <= 1'b1;
      repeat (60) @(posedge clk_sys);
      check("stop_open", drive_cmd.run, 32'h0);
      $display("test three_wire done");
      stop_btn <= 1'b1;
      do_reset();
      repeat (7000) @(posedge clk_sys);
      check("before_ready", drive_cmd.run, 32'h0);
      wait_run(1'b1, 2000);
      do_reset();
      bus(1'b1, 8'h34, 32'h1);
      repeat (9000) @(posedge clk_sys);
      check("protected", drive_cmd.run, 32'h0);
      run_btn <= 1'b0;
      repeat (200) @(posedge clk_sys);
      run_btn <= 1'b1;
      wait_run(1'b1, 300);
      $display("test power_on done");
      complete_run();
   end
endmodule : tb
